/* inc/dpm_pkg.sv */
package dpm_pkg;

   // ***************************************************************
   // Classifier geometry
   // ***************************************************************
   localparam int DPM_NUM_PORTS = 8;
   localparam int DPM_PORT_W = 3;
   localparam int DPM_DS_W = 8;
   localparam int DPM_CP_W = 6;
   localparam int DPM_PRIO_W = 3;
   localparam int DPM_TBL_DEPTH = 64;
   localparam int DPM_DS_CP_LSB = 2;
   localparam int DPM_DS_PREC_LSB = 5;
   localparam int DPM_GROUP_SHIFT = 3;
   localparam int DPM_CNT_W = 16;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam int DPM_ADDR_W = 12;
   localparam int DPM_DATA_W = 32;
   localparam logic [11:0] DPM_OFS_CTRL = 12'h000;
   localparam logic [11:0] DPM_OFS_PORT_EN = 12'h004;
   localparam logic [11:0] DPM_OFS_ALL_PORTS = 12'h008;
   localparam logic [11:0] DPM_OFS_MAP_CNT = 12'h00C;
   localparam logic [11:0] DPM_OFS_LAST = 12'h010;
   localparam logic [3:0] DPM_TBL_PAGE = 4'h1;
   localparam int DPM_TBL_PAGE_LSB = 8;
   localparam int DPM_TBL_IDX_LSB = 2;
   localparam logic [1:0] DPM_ALIGN_OK = 2'h0;
   localparam int DPM_CTRL_EN_BIT = 0;
   localparam int DPM_ALL_EN_BIT = 0;
   localparam int DPM_LAST_PRIO_LSB = 8;
   localparam logic DPM_GLOB_EN_RST = 1'h0;
   localparam logic [7:0] DPM_PORT_EN_RST = 8'h00;
   localparam logic [15:0] DPM_CNT_ONE = 16'h0001;
   localparam logic [31:0] DPM_RD_ZERO = 32'h0000_0000;

   // ***************************************************************
   // Bus slave states
   // ***************************************************************
   typedef enum logic [1:0] {
      DPM_APB_IDLE = 2'b00,
      DPM_APB_ACK = 2'b01
   } dpm_apb_type;

endpackage

/* rtl/dpm_mapper.sv */
// Function
// - Code point is upper six DS bits.
// - Two low unused DS bits ignored.
// - 64 entries, code point indexes directly.
// - Reset table: priority equals code over eight.
// - Default follows the three precedence bits.
// - Classified packets take their table priority.
// - Software rewrites entries; next packets use them.
// - Global enable gates all classification.
// - Per-port enable gates classification per port.
// - All-ports write copies value to every port.
//
// Register access over APB and the address map were chosen for this implementation.
module dpm_mapper
   import dpm_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [DPM_ADDR_W-1:0] i_paddr,
   input wire logic [DPM_DATA_W-1:0] i_pwdata,
   output logic o_pready,
   output logic [DPM_DATA_W-1:0] o_prdata,
   output logic o_pslverr,
   // Packet from the ingress parser
   input wire logic i_pkt_valid,
   input wire logic [DPM_PORT_W-1:0] i_pkt_port,
   input wire logic i_pkt_is_ip,
   input wire logic [DPM_DS_W-1:0] i_pkt_ds,
   input wire logic [DPM_PRIO_W-1:0] i_pkt_prio,
   // Classified result
   output logic o_cls_valid,
   output logic [DPM_PRIO_W-1:0] o_cls_prio,
   output logic o_cls_mapped
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   dpm_apb_type st_r;
   dpm_apb_type st_nxt;
   logic glob_en_r;
   logic [DPM_NUM_PORTS-1:0] port_en_r;
   logic all_en_r;
   logic [DPM_CNT_W-1:0] map_cnt_r;
   logic [DPM_CP_W-1:0] last_cp_r;
   logic [DPM_PRIO_W-1:0] last_prio_r;
   logic tbl_dirty_r;
   logic [DPM_PRIO_W-1:0] tbl_q [DPM_TBL_DEPTH];
   logic [DPM_TBL_DEPTH-1:0] tbl_we_w;

   wire logic acc_w;
   wire logic wr_go_w;
   wire logic aligned_w;
   wire logic [DPM_ADDR_W-1:0] ofs_w;
   wire logic tbl_hit_w;
   wire logic ctrl_hit_w;
   wire logic port_hit_w;
   wire logic all_hit_w;
   wire logic cnt_hit_w;
   wire logic last_hit_w;
   wire logic any_hit_w;
   wire logic [DPM_CP_W-1:0] tbl_idx_w;
   wire logic [DPM_PRIO_W-1:0] wr_prio_w;
   wire logic wr_bit0_w;
   wire logic wr_tbl_w;
   wire logic wr_ctrl_w;
   wire logic wr_port_w;
   wire logic wr_all_w;
   wire logic [DPM_DATA_W-1:0] tbl_rd_w;
   wire logic [DPM_DATA_W-1:0] reg_rd_w;
   wire logic [DPM_DATA_W-1:0] rd_data_w;

   wire logic [DPM_CP_W-1:0] cp_w;
   wire logic [DPM_PRIO_W-1:0] prec_w;
   wire logic port_on_w;
   wire logic cls_on_w;
   wire logic cls_go_w;
   wire logic [DPM_PRIO_W-1:0] lu_prio_w;
   wire logic [DPM_PRIO_W-1:0] prio_nxt;

   // ***************************************************************
   // APB decode
   // ***************************************************************
   // The slave answers one cycle into the access phase, so pready,
   // prdata and pslverr can all come straight from flip-flops.
   assign acc_w = i_psel & i_penable;
   assign wr_go_w = (st_r == DPM_APB_ACK) & acc_w & i_pwrite;
   assign aligned_w = (i_paddr[1:0] == DPM_ALIGN_OK);
   assign ofs_w = i_paddr;
   assign tbl_hit_w = aligned_w &
      (i_paddr[DPM_ADDR_W-1:DPM_TBL_PAGE_LSB] == DPM_TBL_PAGE);
   assign ctrl_hit_w = (ofs_w == DPM_OFS_CTRL);
   assign port_hit_w = (ofs_w == DPM_OFS_PORT_EN);
   assign all_hit_w = (ofs_w == DPM_OFS_ALL_PORTS);
   assign cnt_hit_w = (ofs_w == DPM_OFS_MAP_CNT);
   assign last_hit_w = (ofs_w == DPM_OFS_LAST);
   assign any_hit_w = tbl_hit_w | ctrl_hit_w | port_hit_w | all_hit_w |
      cnt_hit_w | last_hit_w;
   assign tbl_idx_w =
      i_paddr[DPM_TBL_IDX_LSB+DPM_CP_W-1:DPM_TBL_IDX_LSB];
   assign wr_prio_w = i_pwdata[DPM_PRIO_W-1:0];
   assign wr_bit0_w = i_pwdata[DPM_ALL_EN_BIT];
   assign wr_tbl_w = wr_go_w & tbl_hit_w;
   assign wr_ctrl_w = wr_go_w & ctrl_hit_w;
   assign wr_port_w = wr_go_w & port_hit_w;
   assign wr_all_w = wr_go_w & all_hit_w;

   // ***************************************************************
   // APB read data
   // ***************************************************************
   assign tbl_rd_w = DPM_DATA_W'(tbl_q[tbl_idx_w]);
   assign reg_rd_w =
      ctrl_hit_w ? DPM_DATA_W'(glob_en_r) :
      port_hit_w ? DPM_DATA_W'(port_en_r) :
      all_hit_w ? DPM_DATA_W'(all_en_r) :
      cnt_hit_w ? DPM_DATA_W'(map_cnt_r) :
      last_hit_w ? DPM_DATA_W'({last_prio_r,
         (DPM_LAST_PRIO_LSB-DPM_CP_W)'(0), last_cp_r}) :
      DPM_RD_ZERO;
   assign rd_data_w = tbl_hit_w ? tbl_rd_w : reg_rd_w;

   // ***************************************************************
   // APB handshake
   // ***************************************************************
   always_comb begin
      case (st_r)
         DPM_APB_IDLE: begin
            st_nxt = acc_w ? DPM_APB_ACK : DPM_APB_IDLE;
         end
         DPM_APB_ACK: begin
            st_nxt = DPM_APB_IDLE;
         end
         default: begin
            st_nxt = DPM_APB_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= DPM_APB_IDLE;
         o_pready <= 1'b0;
         o_prdata <= DPM_RD_ZERO;
         o_pslverr <= 1'b0;
      end else begin
         st_r <= st_nxt;
         o_pready <= (st_nxt == DPM_APB_ACK);
         o_pslverr <= (st_nxt == DPM_APB_ACK) & ~any_hit_w;
         o_prdata <= (st_nxt == DPM_APB_ACK && !i_pwrite) ?
            rd_data_w : DPM_RD_ZERO;
      end
   end

   // ***************************************************************
   // Enables
   // ***************************************************************
   // A port-enable write and an all-ports write cannot meet in one
   // cycle, so the later one always wins as software expects.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         glob_en_r <= DPM_GLOB_EN_RST;
         port_en_r <= DPM_PORT_EN_RST;
         all_en_r <= 1'b0;
      end else begin
         if (wr_ctrl_w) begin
            glob_en_r <= i_pwdata[DPM_CTRL_EN_BIT];
         end
         if (wr_all_w) begin
            all_en_r <= wr_bit0_w;
            port_en_r <= {DPM_NUM_PORTS{wr_bit0_w}};
         end else if (wr_port_w) begin
            port_en_r <= i_pwdata[DPM_NUM_PORTS-1:0];
         end
      end
   end

   // ***************************************************************
   // Mapping table
   // ***************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < DPM_TBL_DEPTH; gi++) begin : g_tbl
         assign tbl_we_w[gi] = wr_tbl_w &&
            (tbl_idx_w == DPM_CP_W'(gi));
         dpm_prio_entry #(
            .RST_PRIO(DPM_PRIO_W'(gi >> DPM_GROUP_SHIFT))
         ) u_entry (
            .i_mclk(i_mclk),
            .i_nrst(i_nrst),
            .i_we(tbl_we_w[gi]),
            .i_prio(wr_prio_w),
            .o_prio(tbl_q[gi])
         );
      end
   endgenerate

   // Tracks whether the table still holds its reset contents.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         tbl_dirty_r <= 1'b0;
      end else if (wr_tbl_w) begin
         tbl_dirty_r <= 1'b1;
      end
   end

   // ***************************************************************
   // Classification
   // ***************************************************************
   assign cp_w = i_pkt_ds[DPM_DS_W-1:DPM_DS_CP_LSB];
   assign prec_w = i_pkt_ds[DPM_DS_W-1:DPM_DS_PREC_LSB];
   assign port_on_w = port_en_r[i_pkt_port];
   assign cls_on_w = glob_en_r & port_on_w & i_pkt_is_ip;
   assign cls_go_w = i_pkt_valid & cls_on_w;
   assign lu_prio_w = tbl_q[cp_w];
   assign prio_nxt = cls_on_w ? lu_prio_w : i_pkt_prio;

   // A table write lands in the same edge as a lookup, so a packet in
   // the cycle after the write's completing edge sees the new entry.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cls_valid <= 1'b0;
         o_cls_prio <= '0;
         o_cls_mapped <= 1'b0;
      end else begin
         o_cls_valid <= i_pkt_valid;
         o_cls_prio <= i_pkt_valid ? prio_nxt : '0;
         o_cls_mapped <= cls_go_w;
      end
   end

   // The counter wraps; software takes differences between reads.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         map_cnt_r <= '0;
         last_cp_r <= '0;
         last_prio_r <= '0;
      end else if (cls_go_w) begin
         map_cnt_r <= map_cnt_r + DPM_CNT_ONE;
         last_cp_r <= cp_w;
         last_prio_r <= lu_prio_w;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   property p_apb_answer;
      @(posedge i_mclk) disable iff (!i_nrst)
      (st_r == DPM_APB_IDLE && acc_w) |=> o_pready ##1 !o_pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("APB answer not one cycle after access start");

   property p_low_bits_ignored;
      @(posedge i_mclk) disable iff (!i_nrst)
      (cls_go_w && !wr_tbl_w) ##1
      (cls_go_w && !wr_tbl_w && cp_w == $past(cp_w)) |=>
      o_cls_prio == $past(o_cls_prio);
   endproperty
   a_low_bits_ignored: assert property (p_low_bits_ignored)
      else $error("Low DS bits changed the priority");

   property p_tbl_readback;
      @(posedge i_mclk) disable iff (!i_nrst)
      (st_r == DPM_APB_IDLE && acc_w && !i_pwrite && tbl_hit_w) |=>
      o_prdata == DPM_DATA_W'(tbl_q[$past(tbl_idx_w)]);
   endproperty
   a_tbl_readback: assert property (p_tbl_readback)
      else $error("Table read returned the wrong entry");

   property p_reset_table;
      @(posedge i_mclk) disable iff (!i_nrst)
      !tbl_dirty_r |->
      tbl_q[cp_w] == DPM_PRIO_W'(cp_w >> DPM_GROUP_SHIFT);
   endproperty
   a_reset_table: assert property (p_reset_table)
      else $error("Default entry is not code point over eight");

   property p_precedence;
      @(posedge i_mclk) disable iff (!i_nrst)
      (!tbl_dirty_r && cls_go_w && !wr_tbl_w) |=>
      o_cls_mapped && o_cls_prio == $past(prec_w);
   endproperty
   a_precedence: assert property (p_precedence)
      else $error("Default priority differs from precedence bits");

   property p_classify;
      @(posedge i_mclk) disable iff (!i_nrst)
      (cls_go_w && !wr_tbl_w) |=>
      o_cls_valid && o_cls_prio == tbl_q[$past(cp_w)];
   endproperty
   a_classify: assert property (p_classify)
      else $error("Classified priority not taken from table");

   property p_tbl_write;
      @(posedge i_mclk) disable iff (!i_nrst)
      wr_tbl_w |=> tbl_q[$past(tbl_idx_w)] == $past(wr_prio_w) &&
      tbl_dirty_r;
   endproperty
   a_tbl_write: assert property (p_tbl_write)
      else $error("Table write did not land");

   property p_global_off;
      @(posedge i_mclk) disable iff (!i_nrst)
      (i_pkt_valid && !glob_en_r) |=>
      !o_cls_mapped && o_cls_prio == $past(i_pkt_prio);
   endproperty
   a_global_off: assert property (p_global_off)
      else $error("Packet classified while globally disabled");

   property p_port_off;
      @(posedge i_mclk) disable iff (!i_nrst)
      (i_pkt_valid && !port_on_w) |=>
      !o_cls_mapped && o_cls_prio == $past(i_pkt_prio);
   endproperty
   a_port_off: assert property (p_port_off)
      else $error("Packet classified on a disabled port");

   property p_all_ports;
      @(posedge i_mclk) disable iff (!i_nrst)
      wr_all_w |=> port_en_r == {DPM_NUM_PORTS{$past(wr_bit0_w)}};
   endproperty
   a_all_ports: assert property (p_all_ports)
      else $error("All-ports write did not reach every port");

   property p_non_ip;
      @(posedge i_mclk) disable iff (!i_nrst)
      (i_pkt_valid && !i_pkt_is_ip) |=>
      o_cls_valid && !o_cls_mapped && o_cls_prio == $past(i_pkt_prio);
   endproperty
   a_non_ip: assert property (p_non_ip)
      else $error("Non-IP frame priority was altered");

   property p_code_point;
      @(posedge i_mclk) disable iff (!i_nrst)
      (cls_go_w && !wr_tbl_w) |=>
      o_cls_prio == tbl_q[DPM_CP_W'($past(i_pkt_ds) >> DPM_DS_CP_LSB)];
   endproperty
   a_code_point: assert property (p_code_point)
      else $error("Code point not taken from the upper DS bits");

endmodule

/* rtl/dpm_prio_entry.sv */
module dpm_prio_entry
   import dpm_pkg::*;
#(
   parameter logic [DPM_PRIO_W-1:0] RST_PRIO = '0
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Write port
   input wire logic i_we,
   input wire logic [DPM_PRIO_W-1:0] i_prio,
   // Stored priority
   output logic [DPM_PRIO_W-1:0] o_prio
);

   // Each entry resets to its own constant, so the default table needs
   // no boot-time loader.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_prio <= RST_PRIO;
      end else if (i_we) begin
         o_prio <= i_prio;
      end
   end

endmodule

/* tb/dpm_mapper_bench.sv */
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
   num_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module dpm_mapper_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import dpm_pkg::*;

   // ***************************************************************
   // Signals and instances
   // ***************************************************************
   logic i_mclk, i_nrst, i_psel, i_penable, i_pwrite;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd;
   logic o_pready, o_pslverr, err, pend, exp_m;
   logic pv, pip, o_cls_valid, o_cls_mapped;
   logic [2:0] ppt, ppr, o_cls_prio, exp_p;
   logic [7:0] pds;
   int num_errors = 0;
   int num_checks = 0;

   dpm_parser_model i_par (.i_mclk(i_mclk), .o_pkt_valid(pv),
      .o_pkt_port(ppt), .o_pkt_is_ip(pip), .o_pkt_ds(pds),
      .o_pkt_prio(ppr));
   dpm_mapper i_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
      .o_pslverr(o_pslverr), .i_pkt_valid(pv), .i_pkt_port(ppt),
      .i_pkt_is_ip(pip), .i_pkt_ds(pds), .i_pkt_prio(ppr),
      .o_cls_valid(o_cls_valid), .o_cls_prio(o_cls_prio),
      .o_cls_mapped(o_cls_mapped));

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task results;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (n >= 20) begin
         num_errors++;
         results();
      end
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                       input logic ee);
      apb(1'b0, a, 32'h0000_0000);
      `CHK("prdata", e, rd)
      `CHK("pslverr", ee, err)
   endtask

   task automatic check_out();
      if (pend) begin
         `CHK("cls_valid", 1'b1, o_cls_valid)
         `CHK("cls_prio", exp_p, o_cls_prio)
         `CHK("cls_mapped", exp_m, o_cls_mapped)
      end
      pend = 1'b0;
   endtask

   // The result of the previous packet is checked as the next one goes out.
   task automatic pkt(input logic [2:0] pt, input logic ip,
      input logic [7:0] ds, input logic [2:0] pr, input logic [2:0] ep,
      input logic em);
      i_par.send(pt, ip, ds, pr);
      #1 check_out();
      pend = 1'b1;
      exp_p = ep;
      exp_m = em;
   endtask

   task automatic flush();
      i_par.idle();
      #1 check_out();
   endtask

   // ***************************************************************
   // Stimulus
   // ***************************************************************
   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end

   initial begin
      repeat (20000) @(posedge i_mclk);
      num_errors++;
      results();
   end

   initial begin
      {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
      i_nrst = 1'b0;
      pend = 1'b0;
      repeat (10) @(posedge i_mclk);
      i_nrst <= 1'b1;
      rchk(DPM_OFS_CTRL, 32'h0000_0000, 1'b0);
      rchk(DPM_OFS_PORT_EN, 32'h0000_0000, 1'b0);
      rchk(12'h7F0, 32'h0000_0000, 1'b1);
      rchk(12'h002, 32'h0000_0000, 1'b1);
      for (int n = 0; n < 64; n++) begin
         rchk(12'h100 + 12'(4 * n), 32'(n >> 3), 1'b0);
      end
      pkt(3'h3, 1'b1, 8'hFC, 3'h2, 3'h2, 1'b0);
      flush();
      apb(1'b1, DPM_OFS_ALL_PORTS, 32'h0000_0001);
      rchk(DPM_OFS_PORT_EN, 32'h0000_00FF, 1'b0);
      apb(1'b1, DPM_OFS_CTRL, 32'h0000_0001);
      apb(1'b1, DPM_OFS_PORT_EN, 32'h0000_007F);
      for (int n = 0; n < 64; n++) begin
         pkt(3'(n % 7), 1'b1, {6'(n), 2'(n)}, ~3'(n), 3'(n >> 3),
             1'b1);
      end
      pkt(3'h4, 1'b1, 8'hA5, 3'h0, 3'h5, 1'b1);
      pkt(3'h5, 1'b1, 8'hA6, 3'h0, 3'h5, 1'b1);
      pkt(3'h7, 1'b1, 8'hFF, 3'h1, 3'h1, 1'b0);
      pkt(3'h2, 1'b0, 8'hFF, 3'h4, 3'h4, 1'b0);
      flush();
      rchk(DPM_OFS_MAP_CNT, 32'h0000_0042, 1'b0);
      rchk(DPM_OFS_LAST, 32'h0000_0529, 1'b0);
      for (int n = 0; n < 64; n += 9) begin
         apb(1'b1, 12'h100 + 12'(4 * n), 32'((n + 5) & 7));
         pkt(3'h0, 1'b1, {6'(n), 2'h3}, 3'h0, 3'((n + 5) & 7), 1'b1);
         flush();
         rchk(12'h100 + 12'(4 * n), 32'((n + 5) & 7), 1'b0);
      end
      apb(1'b1, DPM_OFS_CTRL, 32'h0000_0000);
      pkt(3'h1, 1'b1, 8'hFC, 3'h5, 3'h5, 1'b0);
      flush();
      apb(1'b1, DPM_OFS_ALL_PORTS, 32'h0000_0000);
      rchk(DPM_OFS_PORT_EN, 32'h0000_0000, 1'b0);
      // A reset in mid-run must bring back table entry 0's default, the global enable and the counter.
      @(posedge i_mclk);
      i_nrst <= 1'b0;
      repeat (3) @(posedge i_mclk);
      i_nrst <= 1'b1;
      rchk(12'h100, 32'h0000_0000, 1'b0);
      rchk(DPM_OFS_CTRL, 32'h0000_0000, 1'b0);
      rchk(DPM_OFS_MAP_CNT, 32'h0000_0000, 1'b0);
      results();
   end
endmodule

/* tb/dpm_parser_model.sv */
module dpm_parser_model
   import dpm_pkg::*;
(
   // Clock
   input wire logic i_mclk,
   // Packet towards the classifier
   output logic o_pkt_valid,
   output logic [DPM_PORT_W-1:0] o_pkt_port,
   output logic o_pkt_is_ip,
   output logic [DPM_DS_W-1:0] o_pkt_ds,
   output logic [DPM_PRIO_W-1:0] o_pkt_prio
);
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************************
   // Parser behaviour
   // ***************************************************************
   initial begin
      o_pkt_valid = 1'b0;
      o_pkt_port = '0;
      o_pkt_is_ip = 1'b0;
      o_pkt_ds = '0;
      o_pkt_prio = '0;
   end

   task automatic send(input logic [2:0] pt, input logic ip,
                       input logic [7:0] ds, input logic [2:0] pr);
      @(posedge i_mclk);
      o_pkt_valid <= 1'b1;
      o_pkt_port <= pt;
      o_pkt_is_ip <= ip;
      o_pkt_ds <= ds;
      o_pkt_prio <= pr;
   endtask

   // Idle fields are inverted so a design that samples them late sees junk.
   task automatic idle();
      @(posedge i_mclk);
      o_pkt_valid <= 1'b0;
      o_pkt_port <= ~o_pkt_port;
      o_pkt_is_ip <= ~o_pkt_is_ip;
      o_pkt_ds <= ~o_pkt_ds;
      o_pkt_prio <= ~o_pkt_prio;
   endtask
endmodule
